// [dv/adcc_host.sv]
`timescale 1ns/1ps
module adcc_host (
  // Clock
  input  wire logic clk_sys,
  // Control port master
  output logic      cs_n,
  output logic      cclk,
  output logic      cdin,
  input  wire logic cdout,
  // Sample drain
  output logic      out_ready
);
  initial begin
    cs_n = 1'b1;
    cclk = 1'b0;
    cdin = 1'b0;
    out_ready = 1'b0;
  end
  // Random stalls so the buffer fills
  always @(posedge clk_sys) out_ready <= ($urandom % 3) != 0;
  // Four-wire frame, MSB first; cclk low three clocks, high four clocks
  task automatic frame(input logic [23:0] tx, input int n, output logic [7:0] rx);
    @(posedge clk_sys);
    cs_n <= 1'b0;
    for (int i = 0; i < 8 * n; i++) begin
      @(posedge clk_sys);
      cclk <= 1'b0;
      cdin <= tx[23 - i];
      repeat (3) @(posedge clk_sys);
      cclk <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rx = {rx[6:0], cdout};
    end
    @(posedge clk_sys);
    cclk <= 1'b0;
    cs_n <= 1'b1;
    // Released line must not look held
    cdin <= ~cdin;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule // adcc_host

// [dv/tb_adcc_top.sv]
`timescale 1ns/1ps
module tb_adcc_top;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic hw = 1'b0, halve = 1'b0, role = 1'b0, fmt = 1'b0, raw_valid = 1'b0, sp = 1'b0;
  logic si = 1'b0, fi = 1'b0, oe;
  logic [10:0] sc = '0;
  logic cs_n, cclk, cdin, cdout, clocks_oe, sclk_out, mod_clk_en, raw_ready, out_valid;
  logic out_ready;
  logic signed [25:0] raw_a = '0, raw_b = '0;
  adcc_pkg::adcc_pair_t out_data;
  adcc_pkg::adcc_cfg_t  cfg_out;
  int error_cnt = 0, tests_run = 0, nf = 0, np = 0, no = 0;
  logic [7:0]  d;
  logic [31:0] x, y;
  logic [47:0] expq[$];
  logic [25:0] c [5] = '{26'h07fffe0, 26'h07fffdf, 26'h3800000, 26'h2000000, 26'h37fffdf};
  initial forever #2 clk_sys = ~clk_sys;
  adcc_top uut (.clk_sys(clk_sys), .rstn(rstn), .hw_mode_pin(hw),
    .master_clock_halve_pin(halve), .role_pin(role), .format_select_pin(fmt),
    .cs_n(cs_n), .cclk(cclk), .cdin(cdin), .cdout(cdout), .cdout_oe(oe),
    .sclk_in(si), .frame_select_clock_in(fi), .sclk_out(sclk_out),
    .frame_select_clock_out(), .clocks_oe(clocks_oe), .mod_clk_en(mod_clk_en),
    .raw_valid(raw_valid), .raw_ready(raw_ready), .raw_a(raw_a), .raw_b(raw_b),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .cfg_out(cfg_out));
  adcc_host u_host (.clk_sys(clk_sys), .cs_n(cs_n), .cclk(cclk), .cdin(cdin),
    .cdout(cdout), .out_ready(out_ready));
  task automatic chk(input string nm, input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [23:0] code(input logic signed [25:0] r);
    int v;
    v = r + 32;
    if (v > 8388607) v = 8388607;
    if (v < -8388608) v = -8388608;
    return v[23:0];
  endfunction
  always @(posedge clk_sys) begin
    if (raw_valid && raw_ready) expq.push_back({code(raw_a), code(raw_b)});
    if (out_valid && out_ready && expq.size() > 0) chk("out_data", out_data, expq.pop_front());
    nf <= nf + int'(sp && !sclk_out);
    np <= np + int'(mod_clk_en && clocks_oe);
    no <= no + int'(oe);
    sp <= sclk_out;
    // Slave clocks only in hardware slave runs: 64 bits in a 2048-cycle frame
    sc <= 11'(sc + 11'h001);
    si <= sc[4] & hw & ~role;
    fi <= sc[10] & hw & ~role;
  end
  task automatic send(input logic [25:0] a, input logic [25:0] b);
    int k;
    raw_valid <= 1'b1;
    raw_a <= a;
    raw_b <= b;
    for (k = 0; k < 300; k++) begin
      @(posedge clk_sys);
      if (raw_ready === 1'b1) break;
    end
    if (k == 300) begin
      chk("raw_ready", 1'b0, 1'b1);
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_host.frame({adcc_pkg::CHIP_ADDR, 1'b0, a, v}, 3, d);
  endtask
  task automatic rd(input logic [7:0] a);
    u_host.frame({adcc_pkg::CHIP_ADDR, 1'b0, a, 8'h00}, 2, d);
    u_host.frame({adcc_pkg::CHIP_ADDR, 1'b1, 16'h0000}, 2, d);
  endtask
  initial begin
    void'($urandom(79691));
    repeat (16) @(posedge clk_sys);
    chk("cfg_rst", cfg_out, 40'h010707a018);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wr(8'h02, 8'h00);
    wr(8'h06, 8'h00);
    rd(8'h06);
    chk("conv_rd", d, 8'h00);
    chk("cdout_oe", {no > 0, oe}, 2'b10);
    for (int i = 0; i < 30; i++) begin
      x = $urandom;
      y = $urandom;
      send(x[25:0], y[25:0]);
    end
    foreach (c[i]) send(c[i], c[4 - i]);
    raw_valid <= 1'b0;
    for (int k = 0; k < 400 && expq.size() > 0; k++) @(posedge clk_sys);
    chk("drained", expq.size() == 0, 1'b1);
    $display("test stream done");
    rd(8'h20);
    chk("ovf", d[2:0], 3'b011);
    wr(8'h06, 8'hc0);
    send(26'h07fffe0, 26'h0000000);
    raw_valid <= 1'b0;
    rd(8'h20);
    chk("ovf_a", d[2:0], 3'b001);
    rd(8'h20);
    chk("ovf_clr", d[2:0], 3'b000);
    $display("test status done");
    for (int r = 0; r < 2; r++) begin
      rstn <= 1'b0;
      hw <= 1'b1;
      halve <= 1'b1;
      role <= r[0];
      fmt <= ~r[0];
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk("ifc", {cfg_out.ifc[7:5], cfg_out.ifc.auto_spd}, {r[0], 1'b1, ~r[0], 1'b1});
      chk("conv_hw", cfg_out.cv[7:4], 4'ha);
      chk("eng_hw", cfg_out.eng[4:0], 5'h18);
      chk("pwr_hw", {cfg_out.p1[4:0], cfg_out.p2[2:0]}, 8'h07);
      chk("clocks_oe", clocks_oe, r[0]);
      wr(8'h06, 8'h00);
      chk("hw_wr", cfg_out.cv[7:4], 4'ha);
      rd(8'h06);
      chk("hw_rd", d, adcc_pkg::CONV_DEF);
      repeat (2200) @(posedge clk_sys);
      rd(8'h20);
      chk("stat_hw", d, {2'b00, r[0] ? adcc_pkg::SPD_SSM : adcc_pkg::SPD_DSM, 4'h4});
    end
    chk("spd", cfg_out.ifc.spd, adcc_pkg::SPD_SSM);
    repeat (14000) @(posedge clk_sys);
    chk("mod_clk", np > 10 && nf - np <= 1 && np - nf <= 1, 1'b1);
    $display("test hardware mode done");
    summarize();
  end
endmodule // tb_adcc_top

// [rtl/adcc_buf2.sv]
`timescale 1ns/1ps
module adcc_buf2 (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  // Fill side
  input  wire logic                in_valid,
  output logic                     in_ready,
  input  wire adcc_pkg::adcc_pair_t in_data,
  // Drain side
  output logic                     out_valid,
  input  wire logic                out_ready,
  output adcc_pkg::adcc_pair_t     out_data
);
  logic [1:0]           cnt_r;
  logic [1:0]           cnt_nxt;
  adcc_pkg::adcc_pair_t spare_r;
  logic                 push;
  logic                 pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    cnt_nxt = cnt_r;
    if (push & ~pop) cnt_nxt = 2'(cnt_r + 2'h1);
    if (pop & ~push) cnt_nxt = 2'(cnt_r - 2'h1);
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cnt_r     <= 2'h0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      in_ready  <= cnt_nxt != 2'h2;
      out_valid <= cnt_nxt != 2'h0;
    end
  end

  // Head always presents the oldest word
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      out_data <= '0;
      spare_r  <= '0;
    end else if (pop) begin
      out_data <= (cnt_r == 2'h2) ? spare_r : in_data;
    end else if (push) begin
      if (cnt_r == 2'h0) out_data <= in_data;
      else spare_r <= in_data;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_BUF_FULL_STALLS: assert property (cnt_r == 2'h2 |-> !in_ready && out_valid)
    else $error("Full buffer still accepts");
  AST_BUF_STALL_KEEPS: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("Stalled word changed or lost");
endmodule // adcc_buf2

// [rtl/adcc_pkg.sv]
// Functional notes
// [R1] Modulator runs at sixty-four times sample rate
// [R2] Exactly one of four speed modes
// [R3] Slave takes serial clocks; master makes them
// [R4] Software mode: all control through control port
// [R5] Hardware mode: reduced set from strap pins
// [R6] Hardware mode: slave autodetects, master single speed
// [R7] Straps set clock halving, role, data format
// [R8] Hardware mode: filters enabled, not frozen
// [R9] Hardware mode: no invert, ramp and crossing on
// [R10] Hardware mode: no mix, no channel swap
// [R11] Samples coded as two's complement words
// [R12] Out of range saturates to extreme codes
// [R13] Saturation sets the overflow status bit
// [R14] Overflow readable in status register 20h
// [R15] Fixed anti-toggle offset added, never removed
// [R16] Filter off: DC coded about the reference
// [R17] Filter controls live in register 06h
// [R18] Two registers power down converter blocks
// [R19] Frozen filter keeps subtracting held estimate
// [R20] Overflow reflects recent samples, cleared by polling
package adcc_pkg;
  typedef enum logic [1:0] {
    SPD_QSM = 2'b00, SPD_HSM = 2'b01, SPD_SSM = 2'b11, SPD_DSM = 2'b10
  } adcc_spd_t;
  typedef enum logic [1:0] {
    CP_ADDR = 2'b00, CP_MAP = 2'b01, CP_DATA = 2'b11, CP_SKIP = 2'b10
  } adcc_cp_t;

  typedef struct packed {
    logic [2:0] rsv; logic pdn_gain_b; logic pdn_gain_a;
    logic pdn_conv_b; logic pdn_conv_a; logic pdn_dev;
  } adcc_pwr1_t;
  typedef struct packed {
    logic [4:0] rsv; logic pdn_bias; logic pdn_pre_b; logic pdn_pre_a;
  } adcc_pwr2_t;
  typedef struct packed {
    logic master; logic halve; logic fmt_lj; logic [1:0] rsv;
    logic auto_spd; adcc_spd_t spd;
  } adcc_ifc_t;
  typedef struct packed {
    logic hpf_en_a; logic frz_a; logic hpf_en_b; logic frz_b; logic [3:0] rsv;
  } adcc_conv_t;
  typedef struct packed {
    logic [2:0] rsv; logic zero_cross; logic soft_ramp; logic invert;
    logic swap; logic mix;
  } adcc_eng_t;
  typedef struct packed {
    logic [1:0] rsv; adcc_spd_t spd; logic rsv2; logic hw; logic ovf_b; logic ovf_a;
  } adcc_stat_t;
  typedef struct packed {
    adcc_pwr1_t p1; adcc_pwr2_t p2; adcc_ifc_t ifc; adcc_conv_t cv; adcc_eng_t eng;
  } adcc_cfg_t;
  typedef struct packed {
    logic signed [23:0] a; logic signed [23:0] b;
  } adcc_pair_t;

  localparam int RAW_W = 26;
  localparam int WORD_W = 24;
  localparam int DIF_W = RAW_W + 1;
  localparam int ACC_W = RAW_W + 2;
  localparam int HPF_SHIFT = 12;

  localparam logic [7:0] REG_PWR1 = 8'h02;
  localparam logic [7:0] REG_PWR2 = 8'h03;
  localparam logic [7:0] REG_IFC = 8'h04;
  localparam logic [7:0] REG_CONV = 8'h06;
  localparam logic [7:0] REG_ENG = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] PWR1_MASK = 8'h1f;
  localparam logic [7:0] PWR2_MASK = 8'h07;
  localparam logic [7:0] IFC_MASK = 8'he7;
  localparam logic [7:0] CONV_MASK = 8'hf0;
  localparam logic [7:0] ENG_MASK = 8'h1f;

  localparam adcc_pwr1_t PWR1_RST = 8'h01;
  localparam adcc_pwr1_t PWR1_HW = 8'h00;
  localparam adcc_pwr2_t PWR2_DOWN = 8'h07;
  localparam adcc_ifc_t IFC_RST = 8'h07;
  localparam adcc_conv_t CONV_DEF = 8'ha0;
  localparam adcc_eng_t ENG_DEF = 8'h18;

  // Arbitrary control-port chip address
  localparam logic [6:0] CHIP_ADDR = 7'h2a;
  localparam logic [2:0] BIT_LAST = 3'h7;

  localparam logic signed [ACC_W-1:0] SAT_HI = 28'sh07fffff;
  localparam logic signed [ACC_W-1:0] SAT_LO = 28'shf800000;
  localparam logic signed [WORD_W-1:0] CODE_MAX = 24'sh7fffff;
  localparam logic signed [WORD_W-1:0] CODE_MIN = 24'sh800000;
  localparam logic signed [ACC_W-1:0] TOGGLE_OFS = 28'sh0000020;

  localparam logic [15:0] DSM_HALF_DIV = 16'h0014;
  localparam logic [4:0] BITS_HALF_FRAME = 5'h1f;
  localparam logic [6:0] TICKS_FRAME = 7'h40;
  localparam logic [15:0] PER_MAX = 16'hffff;
endpackage

// [rtl/adcc_top.sv]
`timescale 1ns/1ps
module adcc_top #(
  parameter logic [15:0] DET_DSM_MAX = 16'h0f00,
  parameter logic [15:0] DET_SSM_MAX = 16'h1e00,
  parameter logic [15:0] DET_HSM_MAX = 16'h3c00
) (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rstn,
  // Strap pins
  input  wire logic                        hw_mode_pin,
  input  wire logic                        master_clock_halve_pin,
  input  wire logic                        role_pin,
  input  wire logic                        format_select_pin,
  // Control port
  input  wire logic                        cs_n,
  input  wire logic                        cclk,
  input  wire logic                        cdin,
  output logic                             cdout,
  output logic                             cdout_oe,
  // Serial port clocks
  input  wire logic                        sclk_in,
  input  wire logic                        frame_select_clock_in,
  output logic                             sclk_out,
  output logic                             frame_select_clock_out,
  output logic                             clocks_oe,
  // Modulator
  output logic                             mod_clk_en,
  // Raw decimator samples
  input  wire logic                        raw_valid,
  output logic                             raw_ready,
  input  wire logic signed [adcc_pkg::RAW_W-1:0] raw_a,
  input  wire logic signed [adcc_pkg::RAW_W-1:0] raw_b,
  // Coded samples
  output logic                             out_valid,
  input  wire logic                        out_ready,
  output adcc_pkg::adcc_pair_t             out_data,
  // Effective configuration
  output adcc_pkg::adcc_cfg_t              cfg_out
);
  logic                   strap_done_r, hw_r, st_master_r, st_halve_r, st_lj_r;
  adcc_pkg::adcc_pwr1_t   pwr1_r;
  adcc_pkg::adcc_pwr2_t   pwr2_r;
  adcc_pkg::adcc_ifc_t    ifc_r;
  adcc_pkg::adcc_conv_t   conv_r;
  adcc_pkg::adcc_eng_t    eng_r;
  adcc_pkg::adcc_cfg_t    eff_r, eff_nxt;
  adcc_pkg::adcc_spd_t    det_spd_r;
  adcc_pkg::adcc_cp_t     cp_st_r;
  adcc_pkg::adcc_stat_t   stat;
  logic                   cclk_q_r, rd_r, cc_rise, cc_fall, byte_end, addr_hit;
  logic                   wr_en, ld_en, stat_clr;
  logic [2:0]             bit_r;
  logic [7:0]             sh_r, map_r, tx_r, rx_byte, ld_addr, rd_data;
  logic [15:0]            div_r, half_div, per_r;
  logic [4:0]             bcnt_r;
  logic                   sclk_q_r, fsc_q_r, m_tick, s_tick, fsc_rise;
  logic signed [adcc_pkg::RAW_W-1:0]  dc_a_r, dc_b_r, xa, xb;
  logic                   ovf_a_r, ovf_b_r, sat_a, sat_b, push;
  logic [adcc_pkg::WORD_W:0]          code_a, code_b;
  logic signed [adcc_pkg::WORD_W-1:0] wa, wb, ma, mb, sa, sb;
  logic signed [adcc_pkg::WORD_W:0]   mono;
  adcc_pkg::adcc_pair_t   buf_in;

  function automatic logic [adcc_pkg::WORD_W:0] code_word(
    input logic signed [adcc_pkg::RAW_W-1:0] x,
    input logic signed [adcc_pkg::RAW_W-1:0] dc,
    input logic sub);
    logic signed [adcc_pkg::ACC_W-1:0] s;
    s = adcc_pkg::ACC_W'(x) - (sub ? adcc_pkg::ACC_W'(dc) : '0)
        + adcc_pkg::TOGGLE_OFS; // R15 R16 R19
    if (s > adcc_pkg::SAT_HI) code_word = {1'b1, adcc_pkg::CODE_MAX}; // R12
    else if (s < adcc_pkg::SAT_LO) code_word = {1'b1, adcc_pkg::CODE_MIN}; // R12
    else code_word = {1'b0, s[adcc_pkg::WORD_W-1:0]}; // R11
  endfunction

  // Leaky estimate of the input DC level
  function automatic logic signed [adcc_pkg::RAW_W-1:0] dc_step(
    input logic signed [adcc_pkg::RAW_W-1:0] x,
    input logic signed [adcc_pkg::RAW_W-1:0] dc);
    logic signed [adcc_pkg::DIF_W-1:0] d;
    d = adcc_pkg::DIF_W'(x) - adcc_pkg::DIF_W'(dc);
    dc_step = adcc_pkg::RAW_W'(dc + adcc_pkg::RAW_W'(d >>> adcc_pkg::HPF_SHIFT));
  endfunction

  // Negating the most negative code would wrap
  function automatic logic signed [adcc_pkg::WORD_W-1:0] inv_word(
    input logic signed [adcc_pkg::WORD_W-1:0] w);
    inv_word = (w == adcc_pkg::CODE_MIN) ? adcc_pkg::CODE_MAX : -w;
  endfunction

  // Straps are caught once, on the first edge after reset release
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      strap_done_r <= 1'b0;
      hw_r         <= 1'b0;
      st_master_r  <= 1'b0;
      st_halve_r   <= 1'b0;
      st_lj_r      <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      hw_r         <= hw_mode_pin; // R5
      st_master_r  <= role_pin; // R7
      st_halve_r   <= master_clock_halve_pin; // R7
      st_lj_r      <= format_select_pin; // R7
    end
  end

  // Control port, sampled on the system clock
  assign cc_rise  = cclk & ~cclk_q_r & ~cs_n;
  assign cc_fall  = ~cclk & cclk_q_r & ~cs_n;
  assign byte_end = cc_rise & (bit_r == adcc_pkg::BIT_LAST);
  assign rx_byte  = {sh_r[6:0], cdin};
  assign addr_hit = rx_byte[7:1] == adcc_pkg::CHIP_ADDR;
  assign wr_en    = byte_end & (cp_st_r == adcc_pkg::CP_DATA) & ~rd_r & ~hw_r; // R4
  assign ld_en    = byte_end & (((cp_st_r == adcc_pkg::CP_ADDR) & addr_hit & rx_byte[0])
                    | ((cp_st_r == adcc_pkg::CP_DATA) & rd_r));
  assign ld_addr  = (cp_st_r == adcc_pkg::CP_DATA) ? 8'(map_r + 8'h01) : map_r;
  assign stat_clr = ld_en & (ld_addr == adcc_pkg::REG_STATUS); // R20

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cclk_q_r <= 1'b0;
      cp_st_r  <= adcc_pkg::CP_ADDR;
      bit_r    <= 3'h0;
      sh_r     <= 8'h00;
      map_r    <= 8'h00;
      rd_r     <= 1'b0;
    end else begin
      cclk_q_r <= cclk;
      if (cs_n) begin
        cp_st_r <= adcc_pkg::CP_ADDR;
        bit_r   <= 3'h0;
      end else if (cc_rise) begin
        sh_r  <= rx_byte;
        bit_r <= 3'(bit_r + 3'h1);
        if (bit_r == adcc_pkg::BIT_LAST) begin
          unique case (cp_st_r)
            adcc_pkg::CP_ADDR: begin
              rd_r    <= rx_byte[0];
              cp_st_r <= !addr_hit ? adcc_pkg::CP_SKIP
                         : (rx_byte[0] ? adcc_pkg::CP_DATA : adcc_pkg::CP_MAP);
            end
            adcc_pkg::CP_MAP: begin
              map_r   <= rx_byte;
              cp_st_r <= adcc_pkg::CP_DATA;
            end
            adcc_pkg::CP_DATA: map_r <= 8'(map_r + 8'h01);
            adcc_pkg::CP_SKIP: cp_st_r <= adcc_pkg::CP_SKIP;
          endcase
        end
      end
    end
  end

  always_comb begin
    stat      = '0;
    stat.spd  = eff_r.ifc.spd;
    stat.hw   = hw_r;
    stat.ovf_a = ovf_a_r; // R14
    stat.ovf_b = ovf_b_r; // R14
    case (ld_addr)
      adcc_pkg::REG_PWR1:   rd_data = pwr1_r;
      adcc_pkg::REG_PWR2:   rd_data = pwr2_r;
      adcc_pkg::REG_IFC:    rd_data = ifc_r;
      adcc_pkg::REG_CONV:   rd_data = conv_r;
      adcc_pkg::REG_ENG:    rd_data = eng_r;
      adcc_pkg::REG_STATUS: rd_data = stat; // R14
      default:              rd_data = 8'h00;
    endcase
  end

  // Read data shifts out on falling control clock
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tx_r     <= 8'h00;
      cdout    <= 1'b0;
      cdout_oe <= 1'b0;
    end else begin
      cdout_oe <= ~cs_n & rd_r & (cp_st_r == adcc_pkg::CP_DATA);
      if (ld_en) tx_r <= rd_data;
      else if (cc_fall) begin
        cdout <= tx_r[7];
        tx_r  <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // Status stays read-only: writes to it are dropped
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pwr1_r <= adcc_pkg::PWR1_RST;
      pwr2_r <= adcc_pkg::PWR2_DOWN;
      ifc_r  <= adcc_pkg::IFC_RST;
      conv_r <= adcc_pkg::CONV_DEF;
      eng_r  <= adcc_pkg::ENG_DEF;
    end else if (wr_en) begin
      case (map_r)
        adcc_pkg::REG_PWR1: pwr1_r <= rx_byte & adcc_pkg::PWR1_MASK; // R18
        adcc_pkg::REG_PWR2: pwr2_r <= rx_byte & adcc_pkg::PWR2_MASK; // R18
        adcc_pkg::REG_IFC:  ifc_r  <= rx_byte & adcc_pkg::IFC_MASK; // R4
        adcc_pkg::REG_CONV: conv_r <= rx_byte & adcc_pkg::CONV_MASK; // R17
        adcc_pkg::REG_ENG:  eng_r  <= rx_byte & adcc_pkg::ENG_MASK; // R4
        default: ;
      endcase
    end
  end

  // Hardware mode ignores the registers entirely
  always_comb begin
    eff_nxt.p1  = pwr1_r;
    eff_nxt.p2  = pwr2_r;
    eff_nxt.ifc = ifc_r;
    eff_nxt.cv  = conv_r;
    eff_nxt.eng = eng_r;
    if (hw_r) begin
      eff_nxt.p1         = adcc_pkg::PWR1_HW; // R5
      eff_nxt.p2         = adcc_pkg::PWR2_DOWN; // R5
      eff_nxt.ifc.master = st_master_r; // R7
      eff_nxt.ifc.halve  = st_halve_r; // R7
      eff_nxt.ifc.fmt_lj = st_lj_r; // R7
      eff_nxt.ifc.auto_spd = 1'b1; // R6
      eff_nxt.cv  = adcc_pkg::CONV_DEF; // R8
      eff_nxt.eng = adcc_pkg::ENG_DEF; // R9 R10
    end
    if (eff_nxt.ifc.auto_spd) begin
      eff_nxt.ifc.spd = eff_nxt.ifc.master ? adcc_pkg::SPD_SSM : det_spd_r; // R6 R2
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) eff_r <= {adcc_pkg::PWR1_RST, adcc_pkg::PWR2_DOWN, adcc_pkg::IFC_RST,
                         adcc_pkg::CONV_DEF, adcc_pkg::ENG_DEF};
    else eff_r <= eff_nxt;
  end
  assign cfg_out = eff_r;

  // Slave: count system clocks per frame to classify the rate
  assign s_tick   = sclk_in & ~sclk_q_r; // R3
  assign fsc_rise = frame_select_clock_in & ~fsc_q_r;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sclk_q_r  <= 1'b0;
      fsc_q_r   <= 1'b0;
      per_r     <= 16'h0000;
      det_spd_r <= adcc_pkg::SPD_SSM;
    end else begin
      sclk_q_r <= sclk_in;
      fsc_q_r  <= frame_select_clock_in;
      if (fsc_rise) begin
        per_r <= 16'h0000;
        if (per_r < DET_DSM_MAX) det_spd_r <= adcc_pkg::SPD_DSM; // R6
        else if (per_r < DET_SSM_MAX) det_spd_r <= adcc_pkg::SPD_SSM;
        else if (per_r < DET_HSM_MAX) det_spd_r <= adcc_pkg::SPD_HSM;
        else det_spd_r <= adcc_pkg::SPD_QSM;
      end else if (per_r != adcc_pkg::PER_MAX) begin
        per_r <= 16'(per_r + 16'h0001);
      end
    end
  end

  // Master: bit clock half period from speed and clock halving
  always_comb begin
    unique case (eff_r.ifc.spd)
      adcc_pkg::SPD_DSM: half_div = adcc_pkg::DSM_HALF_DIV;
      adcc_pkg::SPD_SSM: half_div = 16'(adcc_pkg::DSM_HALF_DIV << 1);
      adcc_pkg::SPD_HSM: half_div = 16'(adcc_pkg::DSM_HALF_DIV << 2);
      adcc_pkg::SPD_QSM: half_div = 16'(adcc_pkg::DSM_HALF_DIV << 3);
    endcase
    if (eff_r.ifc.halve) half_div = 16'(half_div << 1); // R7
  end

  assign m_tick = eff_r.ifc.master & (div_r >= 16'(half_div - 16'h0001)) & sclk_out;

  always_ff @(posedge clk_sys) begin
    if (!rstn || !eff_r.ifc.master) begin
      div_r                  <= 16'h0000;
      sclk_out               <= 1'b0;
      frame_select_clock_out <= 1'b0;
      bcnt_r                 <= 5'h00;
    end else if (div_r >= 16'(half_div - 16'h0001)) begin
      div_r    <= 16'h0000;
      sclk_out <= ~sclk_out; // R3
      if (sclk_out) begin
        bcnt_r <= 5'(bcnt_r + 5'h01);
        if (bcnt_r == adcc_pkg::BITS_HALF_FRAME) begin
          frame_select_clock_out <= ~frame_select_clock_out; // R3
        end
      end
    end else begin
      div_r <= 16'(div_r + 16'h0001);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      clocks_oe  <= 1'b0;
      mod_clk_en <= 1'b0;
    end else begin
      clocks_oe  <= eff_r.ifc.master; // R3
      mod_clk_en <= eff_r.ifc.master ? m_tick : s_tick; // R1
    end
  end

  // Datapath: filter, offset, saturate, then the processing engine
  assign push = raw_valid & raw_ready;

  always_comb begin
    xa = (eff_r.p1.pdn_dev | eff_r.p1.pdn_conv_a) ? '0 : raw_a; // R18
    xb = (eff_r.p1.pdn_dev | eff_r.p1.pdn_conv_b) ? '0 : raw_b; // R18
    code_a = code_word(xa, dc_a_r, eff_r.cv.hpf_en_a); // R11
    code_b = code_word(xb, dc_b_r, eff_r.cv.hpf_en_b); // R11
    sat_a = code_a[adcc_pkg::WORD_W];
    sat_b = code_b[adcc_pkg::WORD_W];
    wa = code_a[adcc_pkg::WORD_W-1:0];
    wb = code_b[adcc_pkg::WORD_W-1:0];
    mono = (adcc_pkg::WORD_W+1)'(wa) + (adcc_pkg::WORD_W+1)'(wb);
    ma = eff_r.eng.mix ? mono[adcc_pkg::WORD_W:1] : wa; // R10
    mb = eff_r.eng.mix ? mono[adcc_pkg::WORD_W:1] : wb; // R10
    sa = eff_r.eng.swap ? mb : ma; // R10
    sb = eff_r.eng.swap ? ma : mb; // R10
    buf_in.a = eff_r.eng.invert ? inv_word(sa) : sa; // R9
    buf_in.b = eff_r.eng.invert ? inv_word(sb) : sb; // R9
  end

  // Frozen channels keep the last estimate in use
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dc_a_r <= '0;
      dc_b_r <= '0;
    end else if (push) begin
      if (eff_r.cv.hpf_en_a && !eff_r.cv.frz_a) dc_a_r <= dc_step(xa, dc_a_r); // R8 R19
      if (eff_r.cv.hpf_en_b && !eff_r.cv.frz_b) dc_b_r <= dc_step(xb, dc_b_r); // R8 R19
    end
  end

  // A new overflow beats a clearing status read
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ovf_a_r <= 1'b0;
      ovf_b_r <= 1'b0;
    end else begin
      ovf_a_r <= (push & sat_a) | (ovf_a_r & ~stat_clr); // R13 R20
      ovf_b_r <= (push & sat_b) | (ovf_b_r & ~stat_clr); // R13 R20
    end
  end

  adcc_buf2 u_buf (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .in_valid  (raw_valid),
    .in_ready  (raw_ready),
    .in_data   (buf_in),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );

  // Checking helpers
  logic [6:0] tk_cnt_r;
  logic       tk_seen_r, fsc_o_rise, fsc_o_q_r;
  always_ff @(posedge clk_sys) fsc_o_q_r <= rstn & frame_select_clock_out;
  assign fsc_o_rise = frame_select_clock_out & ~fsc_o_q_r;
  always_ff @(posedge clk_sys) begin
    if (!rstn || !eff_r.ifc.master) begin
      tk_cnt_r  <= 7'h00;
      tk_seen_r <= 1'b0;
    end else if (fsc_o_rise) begin
      tk_cnt_r  <= {6'h00, mod_clk_en};
      tk_seen_r <= 1'b1;
    end else begin
      tk_cnt_r <= 7'(tk_cnt_r + {6'h00, mod_clk_en});
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_stat_poll;
    stat_clr && !(push && sat_a);
  endsequence
  sequence s_hw_ready;
    strap_done_r && hw_r;
  endsequence

  AST_FRAME_TICKS: assert property ( // R1
    eff_r.ifc.master && $stable(eff_r.ifc) && tk_seen_r && fsc_o_rise
    |-> tk_cnt_r == adcc_pkg::TICKS_FRAME)
    else $error("Master frame does not hold 64 modulator ticks");
  AST_SLAVE_QUIET: assert property (!eff_r.ifc.master [*2] |-> !clocks_oe && !sclk_out) // R3
    else $error("Slave drives serial clocks");
  AST_HW_STRAPS: assert property (s_hw_ready |=> cfg_out.ifc.master == st_master_r // R7
    && cfg_out.ifc.halve == st_halve_r && cfg_out.ifc.fmt_lj == st_lj_r)
    else $error("Hardware mode ignores strap pins");
  AST_HW_MASTER_SSM: assert property ((s_hw_ready and st_master_r) ##1 1 |=> // R6
    cfg_out.ifc.spd == adcc_pkg::SPD_SSM)
    else $error("Hardware master not single speed");
  AST_HW_FILTER: assert property (s_hw_ready |=> cfg_out.cv.hpf_en_a && !cfg_out.cv.frz_a // R8
    && cfg_out.cv.hpf_en_b && !cfg_out.cv.frz_b)
    else $error("Hardware mode filter not running");
  AST_HW_ENGINE: assert property (s_hw_ready |=> !cfg_out.eng.mix && !cfg_out.eng.swap // R10
    && !cfg_out.eng.invert && cfg_out.eng.soft_ramp && cfg_out.eng.zero_cross)
    else $error("Hardware mode engine defaults wrong");
  AST_SAT_CODE: assert property (push && sat_a |-> // R12
    (wa == adcc_pkg::CODE_MAX) != (wa == adcc_pkg::CODE_MIN))
    else $error("Saturated word is not an extreme code");
  AST_OVF_SET: assert property (push && sat_b |=> ovf_b_r [*1] ##0 stat.ovf_b) // R13
    else $error("Overflow not flagged");
  AST_POLL_CLEARS: assert property (s_stat_poll |=> !ovf_a_r) // R20
    else $error("Status poll did not clear overflow");
  AST_OFFSET_ADDED: assert property (push && !eff_r.cv.hpf_en_a && !sat_a // R15
    |-> wa == adcc_pkg::WORD_W'(adcc_pkg::ACC_W'(xa) + adcc_pkg::TOGGLE_OFS))
    else $error("Anti-toggle offset missing");
  AST_FREEZE_HOLDS: assert property (push && eff_r.cv.hpf_en_a && eff_r.cv.frz_a // R19
    |=> $stable(dc_a_r))
    else $error("Frozen estimate moved");
endmodule // adcc_top
